// *** logic/oftc_clock_ctrl.sv ***
// Oscillator divide/trim, timer clock gating and main oscillator mode
`timescale 1ns/1ps
module oftc_clock_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // CPU register access, 8-bit
    input wire logic [19:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Option byte and factory trim, stable around reset
    input wire logic [7:0] option_byte,
    input wire logic [5:0] factory_trim,
    // Watchdog state
    input wire logic watchdog_running,
    // Clock source status
    output logic timer_clock_gate_bit,
    output logic slow_osc_run,
    output logic [2:0] fast_osc_divide,
    output logic [4:0] fast_osc_freq_mhz,
    output logic divide_legal,
    output logic cpu_clock_hold,
    output logic switch_busy,
    output logic [5:0] oscillator_trim,
    output logic main_osc_xtal_en,
    output logic main_osc_extclk_en,
    output logic main_osc_port_mode,
    output logic flash_speed_ok
);
    import oftc_pkg::*;

    // Register state
    logic [7:0] gate_q;
    logic [7:0] gate_d;
    logic [2:0] div_q;
    logic [2:0] div_d;
    logic [5:0] trim_q;
    logic [5:0] trim_d;
    logic [7:0] cmode_q;
    logic [7:0] cmode_d;
    logic load_q;
    logic [2:0] div_used_q;
    logic [2:0] div_used_d;
    // Option byte fields
    logic option_range_bit;
    logic flash_speed_mode_bit1;
    logic flash_speed_mode_bit0;
    logic [2:0] option_div;
    // Address decode and write strobes
    logic sel_gate;
    logic sel_div;
    logic sel_trim;
    logic sel_cmode;
    logic wr_gate;
    logic wr_div;
    logic wr_trim;
    logic wr_cmode;
    // Frequency and switch sequencing
    logic [4:0] new_freq;
    logic new_legal;
    logic [4:0] old_freq;
    logic use_new;
    logic hold;
    logic busy;
    logic [2:0] div_applied;
    logic [4:0] freq_now;
    // Mode, status and read path
    logic [1:0] osc_mode;
    logic speed_ok;
    logic slow_run;
    logic [7:0] rdata_d;

    assign option_range_bit = option_byte[OFTC_OPT_RANGE_BIT];
    assign flash_speed_mode_bit1 = option_byte[OFTC_OPT_FMODE1_BIT];
    assign flash_speed_mode_bit0 = option_byte[OFTC_OPT_FMODE0_BIT];
    assign option_div = option_byte[OFTC_OPT_DIV_MSB:0];

    // Exact address match; any other address reads zero
    assign sel_gate = (reg_addr == OFTC_ADDR_GATE);
    assign sel_div = (reg_addr == OFTC_ADDR_DIV);
    assign sel_trim = (reg_addr == OFTC_ADDR_TRIM);
    assign sel_cmode = (reg_addr == OFTC_ADDR_CMODE);
    // Writes in the load cycle after reset are dropped
    assign wr_gate = reg_wr && sel_gate && !load_q;
    // Writes during a running switch would restart timing; ignored instead
    assign wr_div = reg_wr && sel_div && !busy && !load_q;
    assign wr_trim = reg_wr && sel_trim && !load_q;
    assign wr_cmode = reg_wr && sel_cmode && !load_q;

    assign gate_d = wr_gate ? (reg_wdata & (8'h01 << OFTC_GATE_BIT)) :
        gate_q;
    assign cmode_d = wr_cmode ? (reg_wdata & OFTC_CMODE_MASK) : cmode_q;
    assign div_d = load_q ? option_div :
        (wr_div ? reg_wdata[2:0] : div_q);
    assign trim_d = load_q ? factory_trim :
        (wr_trim ? (reg_wdata[5:0] & OFTC_TRIM_MASK) : trim_q);

    assign rdata_d = sel_gate ? gate_q :
        sel_div ? {5'h00, div_q} :
        sel_trim ? {2'h0, trim_q} :
        sel_cmode ? cmode_q : 8'h00;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            gate_q <= OFTC_GATE_RST;
        end else begin
            gate_q <= gate_d;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_d;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            trim_q <= 6'h00;
        end else begin
            trim_q <= trim_d;
        end
    end

    // Clock mode bits
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmode_q <= OFTC_CMODE_RST;
        end else begin
            cmode_q <= cmode_d;
        end
    end

    // Option inputs are only trusted one edge after reset release
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            load_q <= 1'b1;
        end else begin
            load_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_used_q <= 3'h0;
        end else begin
            div_used_q <= div_used_d;
        end
    end

    oftc_freq_decode u_dec (
        .option_range_bit(option_range_bit),
        .code(div_q),
        .freq_mhz(new_freq),
        .legal(new_legal)
    );

    // Old code decoded the same way, so a prohibited one reads zero
    oftc_freq_decode u_dec_old (
        .option_range_bit(option_range_bit),
        .code(div_used_q),
        .freq_mhz(old_freq),
        .legal()
    );

    oftc_switch_seq u_seq (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .change(wr_div),
        .use_new(use_new),
        .hold(hold),
        .busy(busy)
    );

    // applied code: old code while the old frequency runs
    assign div_used_d = load_q ? option_div :
        (use_new ? div_q : div_used_q);
    assign div_applied = use_new ? div_q : div_used_q;
    assign freq_now = use_new ? new_freq : old_freq;
    // flash range check; a prohibited code is never in range
    assign speed_ok = flash_speed_mode_bit1 && (freq_now != 5'h00) &&
        (flash_speed_mode_bit0 || freq_now <= OFTC_LS_MAX_MHZ);
    assign slow_run = watchdog_running || gate_q[OFTC_GATE_BIT];
    assign osc_mode = {cmode_q[OFTC_EXTERNAL_CLOCK_BIT_BIT], cmode_q[OFTC_OSCILLATOR_SELECT_BIT_BIT]};

    // Read data stands one cycle, zero otherwise
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rdata_d : 8'h00;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_clock_gate_bit <= 1'b0;
            slow_osc_run <= 1'b0;
        end else begin
            timer_clock_gate_bit <= gate_q[OFTC_GATE_BIT];
            slow_osc_run <= slow_run;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fast_osc_divide <= 3'h0;
            fast_osc_freq_mhz <= 5'h00;
        end else begin
            fast_osc_divide <= div_applied;
            fast_osc_freq_mhz <= freq_now;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            divide_legal <= 1'b0;
            flash_speed_ok <= 1'b0;
        end else begin
            divide_legal <= new_legal;
            flash_speed_ok <= speed_ok;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_clock_hold <= 1'b0;
            switch_busy <= 1'b0;
        end else begin
            cpu_clock_hold <= hold;
            switch_busy <= busy;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            oscillator_trim <= 6'h00;
        end else begin
            oscillator_trim <= trim_q;
        end
    end

    // Main oscillator pin mode
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            main_osc_xtal_en <= 1'b0;
            main_osc_extclk_en <= 1'b0;
            main_osc_port_mode <= 1'b1;
        end else begin
            main_osc_xtal_en <= (osc_mode == OFTC_MODE_XTAL);
            main_osc_extclk_en <= (osc_mode == OFTC_MODE_EXTCLK);
            main_osc_port_mode <= (osc_mode == OFTC_MODE_PORT);
        end
    end
endmodule // oftc_clock_ctrl

// *** logic/oftc_freq_decode.sv ***
// Divide code to frequency decode with legality check
`timescale 1ns/1ps
module oftc_freq_decode (
    // Settings
    input wire logic option_range_bit,
    input wire logic [2:0] code,
    // Result in MHz, zero when prohibited
    output logic [4:0] freq_mhz,
    output logic legal
);
    import oftc_pkg::*;
    logic [4:0] lo_freq;
    logic [4:0] hi_freq;
    assign lo_freq = (code <= OFTC_DIV_MAX_LO) ?
        5'(OFTC_LO_BASE_MHZ >> code) : 5'h00;
    assign hi_freq = (code != 3'h0 && code <= OFTC_DIV_MAX_HI) ?
        5'(OFTC_HI_BASE_MHZ >> code) : 5'h00;
    assign freq_mhz = option_range_bit ? hi_freq : lo_freq;
    assign legal = (freq_mhz != 5'h00);
endmodule // oftc_freq_decode

// *** logic/oftc_pkg.sv ***
// Package: register map, field layout and encodings for the clock control
package oftc_pkg;
    localparam logic [19:0] OFTC_ADDR_TRIM = 20'hf00a0;
    localparam logic [19:0] OFTC_ADDR_DIV = 20'hf00a8;
    localparam logic [19:0] OFTC_ADDR_GATE = 20'hf00f3;
    localparam logic [19:0] OFTC_ADDR_CMODE = 20'hfffa0;
    localparam int OFTC_GATE_BIT = 4;
    localparam int OFTC_EXTERNAL_CLOCK_BIT_BIT = 7;
    localparam int OFTC_OSCILLATOR_SELECT_BIT_BIT = 6;
    localparam logic [7:0] OFTC_GATE_RST = 8'h00;
    localparam logic [7:0] OFTC_CMODE_RST = 8'h00;
    localparam logic [5:0] OFTC_TRIM_MASK = 6'h3f;
    localparam logic [2:0] OFTC_DIV_MAX_LO = 3'h3;
    localparam logic [2:0] OFTC_DIV_MAX_HI = 3'h5;
    localparam logic [1:0] OFTC_SW_CNT = 2'h3;
    localparam int OFTC_OPT_RANGE_BIT = 3;
    localparam int OFTC_OPT_FMODE1_BIT = 7;
    localparam int OFTC_OPT_FMODE0_BIT = 6;
    localparam int OFTC_OPT_DIV_MSB = 2;
    localparam logic [7:0] OFTC_CMODE_MASK = 8'hc0;
    localparam logic [4:0] OFTC_LO_BASE_MHZ = 5'h18;
    localparam logic [5:0] OFTC_HI_BASE_MHZ = 6'h20;
    localparam logic [4:0] OFTC_LS_MAX_MHZ = 5'h08;
    typedef enum logic [1:0] {
        OFTC_MODE_PORT = 2'b00,
        OFTC_MODE_XTAL = 2'b01,
        OFTC_MODE_EXTCLK = 2'b11
    } oftc_osc_mode_t;
    typedef enum logic [1:0] {
        OFTC_SW_IDLE = 2'b00,
        OFTC_SW_OLD = 2'b01,
        OFTC_SW_WAIT = 2'b10
    } oftc_sw_state_t;
endpackage

// *** logic/oftc_switch_seq.sv ***
// Divide change sequencer: old-frequency run, then clock hold
`timescale 1ns/1ps
module oftc_switch_seq (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Change request
    input wire logic change,
    // Sequencing status
    output logic use_new,
    output logic hold,
    output logic busy
);
    import oftc_pkg::*;
    oftc_sw_state_t state_q, state_d;
    logic [1:0] cnt_q, cnt_d;
    logic cnt_done;
    assign cnt_done = (cnt_q == OFTC_SW_CNT - 2'h1);
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + 2'h1;
        case (state_q)
            OFTC_SW_IDLE: begin
                cnt_d = 2'h0;
                if (change) begin
                    state_d = OFTC_SW_OLD;
                end
            end
            OFTC_SW_OLD: begin
                if (cnt_done) begin
                    state_d = OFTC_SW_WAIT;
                    cnt_d = 2'h0;
                end
            end
            OFTC_SW_WAIT: begin
                if (cnt_done) begin
                    state_d = OFTC_SW_IDLE;
                end
            end
            default: begin
                state_d = OFTC_SW_IDLE;
                cnt_d = 2'h0;
            end
        endcase
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= OFTC_SW_IDLE;
            cnt_q <= 2'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end
    assign use_new = (state_q != OFTC_SW_OLD);
    assign hold = (state_q == OFTC_SW_WAIT);
    assign busy = (state_q != OFTC_SW_IDLE);
endmodule // oftc_switch_seq

// *** tb/oftc_clock_ctrl_asserts.sv ***
// Assertion checker for the clock control block
`timescale 1ns/1ps
module oftc_clock_ctrl_chk
    import oftc_pkg::*;
(
    // Clock, reset and bus
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [19:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic watchdog_running,
    // Status
    input wire logic timer_clock_gate_bit,
    input wire logic slow_osc_run,
    input wire logic cpu_clock_hold,
    input wire logic switch_busy,
    input wire logic main_osc_xtal_en,
    input wire logic main_osc_extclk_en,
    input wire logic main_osc_port_mode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire wg = reg_wr && reg_addr == OFTC_ADDR_GATE;
    wire wm = reg_wr && reg_addr == OFTC_ADDR_CMODE;
    wire [2:0] md = {main_osc_extclk_en, main_osc_xtal_en, main_osc_port_mode};
    a_gate_follows: assert property (
        wg |-> ##2 timer_clock_gate_bit == $past(reg_wdata[OFTC_GATE_BIT], 2))
        else $error("gate bit wrong");
    a_slow_osc_on: assert property (
        $past(arst_n) |-> slow_osc_run ==
        ($past(watchdog_running) || timer_clock_gate_bit))
        else $error("slow osc run wrong");
    a_hold_three: assert property (
        $rose(cpu_clock_hold) |-> cpu_clock_hold[*3] ##1 !cpu_clock_hold)
        else $error("hold length wrong");
    a_busy_cause: assert property (
        $rose(switch_busy) |-> $past(reg_wr && reg_addr == OFTC_ADDR_DIV, 2))
        else $error("switch without write");
    a_old_then_hold: assert property (
        $rose(switch_busy) |-> !cpu_clock_hold[*3] ##1 cpu_clock_hold[*3])
        else $error("switch order wrong");
    a_mode_xtal: assert property (
        wm && reg_wdata[7:6] == 2'b01 |-> ##2 md == 3'b010)
        else $error("resonator mode wrong");
    a_mode_ext: assert property (
        wm && reg_wdata[7:6] == 2'b11 |-> ##2 md == 3'b100)
        else $error("external clock mode wrong");
    a_mode_port: assert property (
        wm && reg_wdata[7:6] == 2'b00 |-> ##2 md == 3'b001)
        else $error("port mode wrong");
    c_switch: cover property ($rose(cpu_clock_hold));
    c_gate: cover property ($rose(timer_clock_gate_bit));
    c_ext: cover property (main_osc_extclk_en);
endmodule // oftc_clock_ctrl_chk
bind oftc_clock_ctrl oftc_clock_ctrl_chk chk_u (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .watchdog_running(watchdog_running),
    .timer_clock_gate_bit(timer_clock_gate_bit),
    .slow_osc_run(slow_osc_run),
    .cpu_clock_hold(cpu_clock_hold),
    .switch_busy(switch_busy),
    .main_osc_xtal_en(main_osc_xtal_en),
    .main_osc_extclk_en(main_osc_extclk_en),
    .main_osc_port_mode(main_osc_port_mode)
);

// *** tb/oftc_nv_model.sv ***
// Option byte and factory trim store read by the block at reset
`timescale 1ns/1ps
module oftc_nv_model (
    // Image select
    input wire logic alt,
    // Stored values
    output logic [7:0] option_byte,
    output logic [5:0] factory_trim
);
    // Both images use the fast flash mode, so every legal code stays in range
    assign option_byte = alt ? 8'he0 : 8'he9;
    assign factory_trim = 6'h2a;
endmodule // oftc_nv_model

// *** tb/test_osc_freq_trim_and_timer_clock_ctrl.sv ***
// Self-checking bench for the clock control block
`timescale 1ns/1ps
module test_osc_freq_trim_and_timer_clock_ctrl;
    import oftc_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [19:0] reg_addr = 20'h00000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic watchdog_running = 1'b0;
    logic alt = 1'b0;
    logic [7:0] reg_rdata, option_byte;
    logic [5:0] factory_trim, oscillator_trim;
    logic [4:0] fast_osc_freq_mhz;
    logic [2:0] fast_osc_divide;
    logic timer_clock_gate_bit, slow_osc_run, divide_legal, cpu_clock_hold;
    logic switch_busy, main_osc_xtal_en, main_osc_extclk_en;
    logic main_osc_port_mode, flash_speed_ok;
    logic [4:0] hi [8] = '{5'h00, 5'h10, 5'h08, 5'h04,
        5'h02, 5'h01, 5'h00, 5'h00};
    logic [4:0] lo [8] = '{5'h18, 5'h0c, 5'h06, 5'h03,
        5'h00, 5'h00, 5'h00, 5'h00};
    logic [7:0] mx [4] = '{8'h01, 8'h02, 8'h00, 8'h04};
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    always #2.5 core_clk = ~core_clk;
    oftc_nv_model nv_u (.alt(alt), .option_byte(option_byte),
        .factory_trim(factory_trim));
    oftc_clock_ctrl dut_u (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .option_byte(option_byte),
        .factory_trim(factory_trim),
        .watchdog_running(watchdog_running),
        .timer_clock_gate_bit(timer_clock_gate_bit),
        .slow_osc_run(slow_osc_run),
        .fast_osc_divide(fast_osc_divide),
        .fast_osc_freq_mhz(fast_osc_freq_mhz),
        .divide_legal(divide_legal),
        .cpu_clock_hold(cpu_clock_hold),
        .switch_busy(switch_busy),
        .oscillator_trim(oscillator_trim),
        .main_osc_xtal_en(main_osc_xtal_en),
        .main_osc_extclk_en(main_osc_extclk_en),
        .main_osc_port_mode(main_osc_port_mode),
        .flash_speed_ok(flash_speed_ok)
    );
    task automatic conclude();
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
        input string what);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [19:0] a, input logic [7:0] e,
        input string w);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk(reg_rdata, e, w);
    endtask
    task automatic do_reset(input logic a);
        arst_n = 1'b0;
        alt = a;
        idle(6);
        arst_n = 1'b1;
        idle(2);
    endtask
    // Reserved divide bits are set on purpose and must read back clear
    task automatic run_table(input logic [4:0] t [8]);
        for (int c = 0; c < 8; c++) begin
            wr(OFTC_ADDR_DIV, 8'hf8 | 8'(c));
            idle(2);
            if (c > 0) begin
                chk(8'(fast_osc_freq_mhz), 8'(t[c - 1]), "old freq");
            end
            idle(2);
            chk({cpu_clock_hold, switch_busy}, 8'h03, "hold");
            idle(4);
            chk({cpu_clock_hold, switch_busy}, 8'h00, "done");
            chk(8'(fast_osc_divide), 8'(c), "applied");
            chk(8'(flash_speed_ok), 8'(t[c] != 5'h00), "speed");
            chk(8'(fast_osc_freq_mhz), 8'(t[c]), "freq");
            chk(8'(divide_legal), 8'(t[c] != 5'h00), "legal");
            rd(OFTC_ADDR_DIV, 8'(c), "div");
        end
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        do_reset(1'b0);
        rd(OFTC_ADDR_GATE, 8'h00, "gate rst");
        rd(OFTC_ADDR_DIV, 8'h01, "div rst");
        rd(OFTC_ADDR_TRIM, 8'h2a, "trim rst");
        chk(8'(main_osc_port_mode), 8'h01, "port rst");
        wr(OFTC_ADDR_GATE, 8'hff);
        rd(OFTC_ADDR_GATE, 8'h10, "gate");
        chk({timer_clock_gate_bit, slow_osc_run}, 8'h03, "on");
        wr(OFTC_ADDR_GATE, 8'hef);
        idle(2);
        chk({timer_clock_gate_bit, slow_osc_run}, 8'h00, "off");
        watchdog_running = 1'b1;
        idle(2);
        chk(8'(slow_osc_run), 8'h01, "wdt");
        watchdog_running = 1'b0;
        wr(OFTC_ADDR_TRIM, 8'hff);
        rd(OFTC_ADDR_TRIM, 8'h3f, "trim");
        chk(8'(oscillator_trim), 8'h3f, "trim out");
        rd(20'hf00f4, 8'h00, "unmapped");
        for (int m = 0; m < 4; m++) begin
            wr(OFTC_ADDR_CMODE, 8'(m) << 6);
            idle(2);
            chk({main_osc_extclk_en, main_osc_xtal_en, main_osc_port_mode},
                mx[m], "mode");
        end
        // Second write falls inside the switch window and is dropped
        wr(OFTC_ADDR_DIV, 8'h02);
        wr(OFTC_ADDR_DIV, 8'h03);
        idle(8);
        rd(OFTC_ADDR_DIV, 8'h02, "busy drop");
        run_table(hi);
        do_reset(1'b1);
        rd(OFTC_ADDR_DIV, 8'h00, "div rst2");
        run_table(lo);
        conclude();
    end
endmodule // test_osc_freq_trim_and_timer_clock_ctrl
